/* verilog/ptf_formatter.sv */
// PCM timeslot formatter: transmit routing, test patterns, buffer alignment and receive timing
`timescale 1ns/100ps
`default_nettype none
`include "ptf_params.svh"
// Operation
// - No framing search on transmit data; mapping follows external alignment to sync.
// - Synchronous mapping puts first PCM frame into first payload block, aligned starts.
// - Unaligned data is carried as one whole serial stream, ignoring timeslots.
// - One route entry per timeslot selects none, one, two or three channels.
// - Route entry selects serial input, insert input, pattern or previous timeslot.
// - Insert marker is high during sampling of timeslots sourced from insert input.
// - Insert data passes the previous-timeslot buffer, routed by the following entry.
// - Per-timeslot pattern advances only in enabled slots; whole channel may be replaced.
// - Patterns: 2^4-1, 2^15-1, 2^23-1, 14-zero limited 2^20-1, fixed byte.
// - The 2^15-1 sequence is sent inverted.
// - No automatic error injection into the test pattern.
// - No per-timeslot tri-state; drop and insert markers flag selected timeslots.
// - Period sync divides multiframe sync; channel frame start follows by water level.
// - Water level sets offset only on buffer reset command or stuffing error.
// - Receive bit 0 frame 0 placed relative to master channel receive frame.
// - Receive period sync is master frame sync delayed by receive water level.
// - Receive multiframe sync marks programmed bit and frame, data alignment unchanged.
// - Receive timing always from master channel sync, never from data search.
// - Edge select setting adds one clock of delay to receive serial data, drop marker and multiframe sync; all launch on the rising edge.
// - Multiframe sync leads sampling of bit 0 frame 0 by two clocks.
module ptf_formatter #(
	parameter int NUM_CH = 3,
	parameter int NUM_TS = 64
) (
	// Clock and reset
	input  wire logic              CLK_I,
	input  wire logic              RST_N_I,
	// Processor port, multiplexed address and data
	input  wire logic [7:0]        CPU_AD_I,
	output logic      [7:0]        CPU_AD_O,
	output logic                   CPU_AD_OE_O,
	input  wire logic              CPU_ALE_I,
	input  wire logic              CPU_CS_N_I,
	input  wire logic              CPU_RD_N_I,
	input  wire logic              CPU_WR_N_I,
	input  wire logic              CPU_BUS_SEL_I,
	// Transmit PCM side
	input  wire logic              TX_SERIAL_IN_I,
	input  wire logic              INSERT_DATA_IN_I,
	output logic                   MULTIFRAME_SYNC_OUT_O,
	output logic                   INSERT_MARK_O,
	// Transmit channel side
	output logic [NUM_CH-1:0]      TX_CH_DATA_O,
	output logic [NUM_CH-1:0]      TX_CH_VALID_O,
	output logic                   TX_PERIOD_SYNC_O,
	output logic [NUM_CH-1:0]      TX_CH_FRAME_START_O,
	input  wire logic [NUM_CH-1:0] TX_STUFF_ERR_I,
	// Receive channel side
	input  wire logic [NUM_CH-1:0] HDSL_RX_SYNC_REF_I,
	input  wire logic [NUM_CH-1:0] RX_CH_DATA_I,
	output logic [NUM_CH-1:0]      RX_CH_TAKE_O,
	// Receive PCM side
	output logic                   RX_SERIAL_OUT_O,
	output logic                   RX_MULTIFRAME_SYNC_OUT_O,
	output logic                   DROP_MARK_O,
	output logic                   RX_PERIOD_SYNC_O
);
	// ****************************************************************
	// Processor port
	// ****************************************************************
	logic [7:0] addr_q, addr_d, wdat_q, wdat_d, rdat_q, rdat_d;
	logic       ale_q, wr_act_q;
	logic       rd_act, wr_act, wr_pulse;
	logic [7:0] tx_level_q [NUM_CH];
	logic [7:0] rx_bit_lo_q, rx_bit_hi_q, rx_frm_off_q, mf_len_q, mf_per_q, hframe_q, rx_level_q;
	logic [7:0] edge_q, pat_q, master_q, fill_q, scope_q, frame_hi_q, frame_lo_q;
	logic [5:0] tbl_idx_q;
	logic [7:0] tx_route_table [NUM_TS];
	logic [7:0] comb_tbl [NUM_TS];
	logic [NUM_CH-1:0] rst_cmd;
	assign rd_act = !CPU_CS_N_I && !CPU_RD_N_I && (!CPU_BUS_SEL_I || CPU_WR_N_I);
	assign wr_act = CPU_BUS_SEL_I ? (!CPU_CS_N_I && !CPU_RD_N_I && !CPU_WR_N_I) : (!CPU_CS_N_I && !CPU_WR_N_I);
	assign wr_pulse = wr_act_q && !wr_act;
	assign CPU_AD_OE_O = rd_act;
	assign CPU_AD_O = rdat_q;
	always_comb
	begin
		addr_d = (ale_q && !CPU_ALE_I) ? CPU_AD_I : addr_q;
		wdat_d = wr_act ? CPU_AD_I : wdat_q;
		rdat_d = 8'h00;
		for (int c = 0; c < NUM_CH; c++)
		begin
			if (addr_q == `PTF_ADDR_TX_LEVEL + 8'(c) * `PTF_ADDR_CH_STRIDE)
				rdat_d = tx_level_q[c];
			rst_cmd[c] = wr_pulse && (addr_q == `PTF_ADDR_TX_RST_CMD + 8'(c) * `PTF_ADDR_CH_STRIDE);
		end
		case (addr_q)
			`PTF_ADDR_RX_BIT_LO:    rdat_d = rx_bit_lo_q;
			`PTF_ADDR_RX_BIT_HI:    rdat_d = rx_bit_hi_q;
			`PTF_ADDR_RX_FRAME:     rdat_d = rx_frm_off_q;
			`PTF_ADDR_MF_LEN:       rdat_d = mf_len_q;
			`PTF_ADDR_MF_PER:       rdat_d = mf_per_q;
			`PTF_ADDR_FRAME_LO:     rdat_d = frame_lo_q;
			`PTF_ADDR_FRAME_HI:     rdat_d = frame_hi_q;
			`PTF_ADDR_HDSL_FRAME_LENGTH:   rdat_d = hframe_q;
			`PTF_ADDR_RX_LEVEL:     rdat_d = rx_level_q;
			`PTF_ADDR_TBL_INDEX:    rdat_d = {2'h0, tbl_idx_q};
			`PTF_ADDR_CMD_EDGE:     rdat_d = edge_q;
			`PTF_ADDR_CMD_PATTERN:  rdat_d = pat_q;
			`PTF_ADDR_CMD_MASTER:   rdat_d = master_q;
			`PTF_ADDR_FILL:         rdat_d = fill_q;
			`PTF_ADDR_TX_ROUTE_TABLE:    rdat_d = tx_route_table[tbl_idx_q];
			`PTF_ADDR_RX_COMBINE_TABLE:  rdat_d = comb_tbl[tbl_idx_q];
			`PTF_ADDR_CMD_SCOPE:    rdat_d = scope_q;
			default:                rdat_d = rdat_d;
		endcase
	end
	always_ff @(posedge CLK_I)
	begin
		ale_q    <= RST_N_I ? CPU_ALE_I : 1'b0;
		wr_act_q <= RST_N_I ? wr_act : 1'b0;
		addr_q   <= RST_N_I ? addr_d : `PTF_RST_BYTE;
		wdat_q   <= RST_N_I ? wdat_d : `PTF_RST_BYTE;
		rdat_q   <= RST_N_I ? rdat_d : `PTF_RST_BYTE;
		if (!RST_N_I)
		begin
			for (int c = 0; c < NUM_CH; c++)
				tx_level_q[c] <= `PTF_RST_BYTE;
			for (int t = 0; t < NUM_TS; t++)
			begin
				tx_route_table[t] <= `PTF_RST_BYTE;
				comb_tbl[t]  <= `PTF_RST_BYTE;
			end
			{rx_bit_lo_q, rx_bit_hi_q, rx_frm_off_q, hframe_q, rx_level_q} <= '0;
			{edge_q, pat_q, master_q, fill_q, scope_q} <= '0;
			frame_lo_q <= 8'(`PTF_RST_FRAME_LEN);
			frame_hi_q <= {7'h00, 1'(`PTF_RST_FRAME_LEN >> 8)};
			mf_len_q   <= `PTF_RST_MF_LEN;
			mf_per_q   <= `PTF_RST_MF_PER;
			tbl_idx_q  <= 6'h00;
		end
		else if (wr_pulse)
		begin
			for (int c = 0; c < NUM_CH; c++)
				if (addr_q == `PTF_ADDR_TX_LEVEL + 8'(c) * `PTF_ADDR_CH_STRIDE)
					tx_level_q[c] <= wdat_q;
			case (addr_q)
				`PTF_ADDR_RX_BIT_LO:    rx_bit_lo_q <= wdat_q;
				`PTF_ADDR_RX_BIT_HI:    rx_bit_hi_q <= wdat_q;
				`PTF_ADDR_RX_FRAME:     rx_frm_off_q <= wdat_q;
				`PTF_ADDR_MF_LEN:       mf_len_q <= wdat_q;
				`PTF_ADDR_MF_PER:       mf_per_q <= wdat_q;
				`PTF_ADDR_FRAME_LO:     frame_lo_q <= wdat_q;
				`PTF_ADDR_FRAME_HI:     frame_hi_q <= {7'h00, wdat_q[0]};
				`PTF_ADDR_HDSL_FRAME_LENGTH:   hframe_q <= wdat_q;
				`PTF_ADDR_RX_LEVEL:     rx_level_q <= wdat_q;
				`PTF_ADDR_TBL_INDEX:    tbl_idx_q <= wdat_q[5:0];
				`PTF_ADDR_CMD_EDGE:     edge_q <= wdat_q;
				`PTF_ADDR_CMD_PATTERN:  pat_q <= wdat_q;
				`PTF_ADDR_CMD_MASTER:   master_q <= wdat_q;
				`PTF_ADDR_FILL:         fill_q <= wdat_q;
				`PTF_ADDR_TX_ROUTE_TABLE:    tx_route_table[tbl_idx_q] <= wdat_q;
				`PTF_ADDR_RX_COMBINE_TABLE:  comb_tbl[tbl_idx_q] <= wdat_q;
				`PTF_ADDR_CMD_SCOPE:    scope_q <= wdat_q;
				default:                tbl_idx_q <= tbl_idx_q;
			endcase
		end
	end
	// ****************************************************************
	// Transmit timebase and routing
	// ****************************************************************
	logic [8:0] frame_len, tx_bit_q, tx_bit_d;
	logic [7:0] tx_frm_q, tx_frm_d, tx_mfc_q, tx_mfc_d, prev_q, prev_d;
	logic       multiframe_sync_out_q, multiframe_sync_out_d, tx_period;
	logic [5:0] ts;
	logic [2:0] bp;
	logic [7:0] entry;
	ptf_pkg::ptf_src_t src;
	logic [NUM_CH-1:0] dest, txd_q, txd_d, txv_q, txv_d;
	logic       async_map, whole, pat_bit, sel_bit, pat_adv;
	assign frame_len = {frame_hi_q[0], frame_lo_q};
	assign async_map = edge_q[`PTF_EDGE_ASYNC_BIT];
	assign whole = scope_q[`PTF_SCOPE_WHOLE_BIT] && (pat_q[2:0] != ptf_pkg::PTF_PAT_OFF);
	assign ts = tx_bit_q[8:3];
	assign bp = tx_bit_q[2:0];
	assign tx_period = (tx_bit_q == 9'h000) && (tx_frm_q == 8'h00) && (tx_mfc_q == 8'h00);
	always_comb
	begin
		tx_bit_d = (tx_bit_q >= frame_len - 9'h001) ? 9'h000 : tx_bit_q + 9'h001;
		tx_frm_d = tx_frm_q;
		tx_mfc_d = tx_mfc_q;
		if (tx_bit_d == 9'h000)
			tx_frm_d = (tx_frm_q >= mf_len_q - 8'h01) ? 8'h00 : tx_frm_q + 8'h01;
		if (tx_bit_d == 9'h000 && tx_frm_d == 8'h00)
			tx_mfc_d = (tx_mfc_q >= mf_per_q - 8'h01) ? 8'h00 : tx_mfc_q + 8'h01;
		multiframe_sync_out_d = (tx_bit_d == frame_len - `PTF_MULTIFRAME_SYNC_OUT_LEAD) && (tx_frm_d == mf_len_q - 8'h01);
		// Free-running timebase; data is never inspected for framing
		entry = async_map ? tx_route_table[0] : tx_route_table[ts];
		src = ptf_pkg::ptf_src_t'(entry[`PTF_ROUTE_SRC_LSB +: 2]);
		if (whole)
			src = ptf_pkg::PTF_SRC_PATTERN;
		else if (async_map)
			src = ptf_pkg::PTF_SRC_SERIAL;
		dest = entry[`PTF_ROUTE_DEST_LSB +: NUM_CH];
		if (src == ptf_pkg::PTF_SRC_INSERT)
			dest = '0;
		case (src)
			ptf_pkg::PTF_SRC_SERIAL:   sel_bit = TX_SERIAL_IN_I;
			ptf_pkg::PTF_SRC_INSERT:   sel_bit = INSERT_DATA_IN_I;
			ptf_pkg::PTF_SRC_PATTERN:  sel_bit = pat_bit;
			ptf_pkg::PTF_SRC_PREVIOUS: sel_bit = prev_q[bp];
			default:                   sel_bit = TX_SERIAL_IN_I;
		endcase
		prev_d = prev_q;
		prev_d[bp] = sel_bit;
		pat_adv = (src == ptf_pkg::PTF_SRC_PATTERN);
		txd_d = {NUM_CH{sel_bit}};
		txv_d = dest;
	end
	assign INSERT_MARK_O = (src == ptf_pkg::PTF_SRC_INSERT);
	assign MULTIFRAME_SYNC_OUT_O = multiframe_sync_out_q;
	assign TX_CH_DATA_O = txd_q;
	assign TX_CH_VALID_O = txv_q;
	assign TX_PERIOD_SYNC_O = tx_period;
	always_ff @(posedge CLK_I)
	begin
		tx_bit_q <= RST_N_I ? tx_bit_d : 9'h000;
		tx_frm_q <= RST_N_I ? tx_frm_d : 8'h00;
		tx_mfc_q <= RST_N_I ? tx_mfc_d : 8'h00;
		multiframe_sync_out_q  <= RST_N_I ? multiframe_sync_out_d : 1'b0;
		prev_q   <= RST_N_I ? prev_d : 8'h00;
		txd_q    <= RST_N_I ? txd_d : '0;
		txv_q    <= RST_N_I ? txv_d : '0;
	end
	// ****************************************************************
	// Test pattern generator
	// ****************************************************************
	logic [22:0] lfsr_q, lfsr_d;
	logic [3:0]  zcnt_q, zcnt_d;
	logic [2:0]  fix_q, fix_d;
	logic        fb;
	ptf_pkg::ptf_pat_t pmode;
	assign pmode = ptf_pkg::ptf_pat_t'(pat_q[2:0]);
	always_comb
	begin
		case (pmode)
			ptf_pkg::PTF_PAT_P4:    begin fb = lfsr_q[3] ^ lfsr_q[2];   pat_bit = lfsr_q[3];  end
			ptf_pkg::PTF_PAT_P15:   begin fb = lfsr_q[14] ^ lfsr_q[13]; pat_bit = !lfsr_q[14]; end
			ptf_pkg::PTF_PAT_P23:   begin fb = lfsr_q[22] ^ lfsr_q[17]; pat_bit = lfsr_q[22]; end
			ptf_pkg::PTF_PAT_QRSS:  begin fb = lfsr_q[19] ^ lfsr_q[16];
				pat_bit = (zcnt_q >= `PTF_QRSS_ZERO_LIMIT) || lfsr_q[19]; end
			ptf_pkg::PTF_PAT_FIXED: begin fb = 1'b0; pat_bit = fill_q[3'h7 - fix_q]; end
			default:                begin fb = 1'b0; pat_bit = 1'b0; end
		endcase
		// Pattern leaves unaltered; no error insertion path exists
		lfsr_d = lfsr_q;
		zcnt_d = zcnt_q;
		fix_d  = fix_q;
		if (pat_adv)
		begin
			lfsr_d = {lfsr_q[21:0], fb | (lfsr_q == 23'h000000)};
			zcnt_d = pat_bit ? 4'h0 : zcnt_q + 4'h1;
			fix_d  = fix_q + 3'h1;
		end
	end
	always_ff @(posedge CLK_I)
	begin
		lfsr_q <= RST_N_I ? lfsr_d : `PTF_RST_LFSR;
		zcnt_q <= RST_N_I ? zcnt_d : 4'h0;
		fix_q  <= RST_N_I ? fix_d : 3'h0;
	end
	// ****************************************************************
	// Transmit buffer alignment per channel
	// ****************************************************************
	ptf_pkg::ptf_align_t al_q [NUM_CH];
	ptf_pkg::ptf_align_t al_d [NUM_CH];
	logic [7:0] lat_q [NUM_CH];
	logic [7:0] lat_d [NUM_CH];
	logic [7:0] dly_q [NUM_CH];
	logic [7:0] dly_d [NUM_CH];
	logic [NUM_CH-1:0] fs;
	always_comb
	begin
		for (int c = 0; c < NUM_CH; c++)
		begin
			al_d[c]  = al_q[c];
			lat_d[c] = lat_q[c];
			dly_d[c] = dly_q[c];
			fs[c]    = 1'b0;
			if (rst_cmd[c] || TX_STUFF_ERR_I[c])
				lat_d[c] = tx_level_q[c];
			case (al_q[c])
				ptf_pkg::PTF_AL_WAIT: if (rst_cmd[c] || TX_STUFF_ERR_I[c]) al_d[c] = ptf_pkg::PTF_AL_RUN;
				ptf_pkg::PTF_AL_RUN:
					if (tx_period)
					begin
						fs[c] = (lat_q[c] == 8'h00);
						al_d[c] = fs[c] ? ptf_pkg::PTF_AL_RUN : ptf_pkg::PTF_AL_DELAY;
						dly_d[c] = lat_q[c] - 8'h01;
					end
				ptf_pkg::PTF_AL_DELAY:
				begin
					dly_d[c] = dly_q[c] - 8'h01;
					if (dly_q[c] == 8'h00)
					begin
						fs[c] = 1'b1;
						al_d[c] = ptf_pkg::PTF_AL_RUN;
					end
				end
				default: al_d[c] = ptf_pkg::PTF_AL_WAIT;
			endcase
		end
	end
	assign TX_CH_FRAME_START_O = fs;
	always_ff @(posedge CLK_I)
	begin
		for (int c = 0; c < NUM_CH; c++)
		begin
			al_q[c]  <= RST_N_I ? al_d[c] : ptf_pkg::PTF_AL_WAIT;
			lat_q[c] <= RST_N_I ? lat_d[c] : 8'h00;
			dly_q[c] <= RST_N_I ? dly_d[c] : 8'h00;
		end
	end
	// ****************************************************************
	// Receive timebase
	// ****************************************************************
	logic [8:0] rx_bit_q, rx_bit_d;
	logic [7:0] rx_frm_q, rx_frm_d, rdly_q, rdly_d, comb;
	logic       rarm_q, rarm_d, master_sync, rx6, rsel;
	logic       rs1_q, rs2_q, dr1_q, dr2_q, rm1_q, rm2_q, rs_d, rm_d;
	logic [1:0] cidx;
	assign master_sync = HDSL_RX_SYNC_REF_I[master_q[1:0]];
	assign rx6 = (master_sync && rx_level_q == 8'h00) || (rarm_q && rdly_q == 8'h00);
	assign comb = comb_tbl[rx_bit_q[8:3]];
	assign cidx = comb[`PTF_COMB_CH_LSB +: 2];
	assign rsel = edge_q[`PTF_EDGE_RX_BIT];
	always_comb
	begin
		rarm_d = rarm_q && !rx6;
		rdly_d = rdly_q - 8'h01;
		if (master_sync && rx_level_q != 8'h00)
		begin
			rarm_d = 1'b1;
			rdly_d = rx_level_q - 8'h01;
		end
		rx_bit_d = (rx_bit_q >= frame_len - 9'h001) ? 9'h000 : rx_bit_q + 9'h001;
		rx_frm_d = rx_frm_q;
		if (rx_bit_d == 9'h000)
			rx_frm_d = (rx_frm_q >= mf_len_q - 8'h01) ? 8'h00 : rx_frm_q + 8'h01;
		if (rx6)
		begin
			rx_bit_d = 9'h000;
			rx_frm_d = 8'h00;
		end
		RX_CH_TAKE_O = '0;
		rs_d = 1'b1;
		if (cidx != 2'h0 && 32'(cidx) <= NUM_CH)
		begin
			RX_CH_TAKE_O[cidx - 2'h1] = 1'b1;
			rs_d = RX_CH_DATA_I[cidx - 2'h1];
		end
		rm_d = ({7'h00, rx_bit_q} == {rx_bit_hi_q, rx_bit_lo_q}) && (rx_frm_q == rx_frm_off_q);
	end
	assign RX_PERIOD_SYNC_O = rx6;
	assign RX_SERIAL_OUT_O = rsel ? rs2_q : rs1_q;
	assign DROP_MARK_O = rsel ? dr2_q : dr1_q;
	assign RX_MULTIFRAME_SYNC_OUT_O = rsel ? rm2_q : rm1_q;
	always_ff @(posedge CLK_I)
	begin
		rarm_q   <= RST_N_I ? rarm_d : 1'b0;
		rdly_q   <= RST_N_I ? rdly_d : 8'h00;
		rx_bit_q <= RST_N_I ? rx_bit_d : 9'h000;
		rx_frm_q <= RST_N_I ? rx_frm_d : 8'h00;
		rs1_q    <= RST_N_I ? rs_d : 1'b1;
		dr1_q    <= RST_N_I ? comb[`PTF_COMB_DROP_BIT] : 1'b0;
		rm1_q    <= RST_N_I ? rm_d : 1'b0;
		rs2_q    <= RST_N_I ? rs1_q : 1'b1;
		dr2_q    <= RST_N_I ? dr1_q : 1'b0;
		rm2_q    <= RST_N_I ? rm1_q : 1'b0;
	end
	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	property p_multiframe_sync_out_lead;
		multiframe_sync_out_q && frame_len > 9'h003 |-> ##2 (tx_bit_q == 9'h000 && tx_frm_q == 8'h00);
	endproperty
	a_multiframe_sync_out_lead: assert property (p_multiframe_sync_out_lead) else $error("multiframe_sync_out lead wrong");
	property p_insert_no_route;
		INSERT_MARK_O |=> TX_CH_VALID_O == '0;
	endproperty
	a_insert_no_route: assert property (p_insert_no_route) else $error("insert slot routed");
	property p_prev_repeat;
		src == ptf_pkg::PTF_SRC_PREVIOUS |=> TX_CH_DATA_O[0] == $past(prev_q[bp]);
	endproperty
	a_prev_repeat: assert property (p_prev_repeat) else $error("previous repeat wrong");
	property p_insert_mark;
		!whole && !async_map && tx_route_table[ts][4:3] == 2'h1 |-> INSERT_MARK_O;
	endproperty
	a_insert_mark: assert property (p_insert_mark) else $error("insert marker missing");
	property p_qrss_limit;
		pmode == ptf_pkg::PTF_PAT_QRSS && zcnt_q == `PTF_QRSS_ZERO_LIMIT |-> pat_bit;
	endproperty
	a_qrss_limit: assert property (p_qrss_limit) else $error("qrss zero run too long");
	property p_pat_hold;
		!pat_adv |=> $stable(lfsr_q);
	endproperty
	a_pat_hold: assert property (p_pat_hold) else $error("pattern moved outside slot");
	property p_lat_only_cmd;
		!$stable(lat_q[0]) |-> $past(rst_cmd[0] || TX_STUFF_ERR_I[0]);
	endproperty
	a_lat_only_cmd: assert property (p_lat_only_cmd) else $error("offset changed");
	property p_rx_align;
		rx6 |=> rx_bit_q == 9'h000 && rx_frm_q == 8'h00;
	endproperty
	a_rx_align: assert property (p_rx_align) else $error("rx frame not aligned");
	property p_rx_delay;
		master_sync && rx_level_q == 8'h02 && !rarm_q ##1 !master_sync [*2] |-> rx6;
	endproperty
	a_rx_delay: assert property (p_rx_delay) else $error("rx sync delay wrong");
	property p_frame_start;
		al_q[0] == ptf_pkg::PTF_AL_RUN && tx_period && lat_q[0] == 8'h01 |=> fs[0];
	endproperty
	a_frame_start: assert property (p_frame_start) else $error("frame start offset wrong");
	c_insert: cover property (INSERT_MARK_O ##1 src == ptf_pkg::PTF_SRC_PREVIOUS);
	c_frame_start: cover property (rst_cmd[0] ##[1:1000] fs[0]);
	c_rx_sync: cover property (rx6 ##[1:1000] RX_MULTIFRAME_SYNC_OUT_O);
endmodule : ptf_formatter
`default_nettype wire

/* verilog/ptf_params.svh */
// Register offsets, field positions, reset values and timing counts of the timeslot formatter
`ifndef PTF_PARAMS_SVH
`define PTF_PARAMS_SVH
// ****************************************************************
// Register offsets
// ****************************************************************
`define PTF_ADDR_TX_LEVEL     8'h05
`define PTF_ADDR_TX_RST_CMD   8'h0d
`define PTF_ADDR_CH_STRIDE    8'h40
`define PTF_ADDR_RX_BIT_LO    8'hc3
`define PTF_ADDR_RX_BIT_HI    8'hc4
`define PTF_ADDR_RX_FRAME     8'hc5
`define PTF_ADDR_MF_LEN       8'hc6
`define PTF_ADDR_MF_PER       8'hc7
`define PTF_ADDR_FRAME_LO     8'hc8
`define PTF_ADDR_FRAME_HI     8'hc9
`define PTF_ADDR_HDSL_FRAME_LENGTH   8'hca
`define PTF_ADDR_RX_LEVEL     8'hcd
`define PTF_ADDR_TBL_INDEX    8'hdf
`define PTF_ADDR_CMD_EDGE     8'he6
`define PTF_ADDR_CMD_PATTERN  8'he7
`define PTF_ADDR_CMD_MASTER   8'he9
`define PTF_ADDR_FILL         8'hea
`define PTF_ADDR_TX_ROUTE_TABLE    8'hed
`define PTF_ADDR_RX_COMBINE_TABLE  8'hee
`define PTF_ADDR_CMD_SCOPE    8'hf3
// ****************************************************************
// Field positions
// ****************************************************************
`define PTF_ROUTE_DEST_LSB    0
`define PTF_ROUTE_SRC_LSB     3
`define PTF_COMB_CH_LSB       0
`define PTF_COMB_DROP_BIT     7
`define PTF_EDGE_RX_BIT       0
`define PTF_EDGE_ASYNC_BIT    1
`define PTF_SCOPE_WHOLE_BIT   0
// ****************************************************************
// Reset values and timing counts
// ****************************************************************
`define PTF_RST_FRAME_LEN     9'h100
`define PTF_RST_MF_LEN        8'h10
`define PTF_RST_MF_PER        8'h01
`define PTF_RST_BYTE          8'h00
`define PTF_RST_LFSR          23'h7fffff
`define PTF_MULTIFRAME_SYNC_OUT_LEAD        9'h002
`define PTF_QRSS_ZERO_LIMIT   4'he
`endif

/* verilog/ptf_pkg.sv */
// Types shared by the timeslot formatter
`default_nettype none
package ptf_pkg;
	typedef enum logic [1:0] {
		PTF_SRC_SERIAL   = 2'h0,
		PTF_SRC_INSERT   = 2'h1,
		PTF_SRC_PATTERN  = 2'h2,
		PTF_SRC_PREVIOUS = 2'h3
	} ptf_src_t;
	typedef enum logic [2:0] {
		PTF_PAT_OFF   = 3'h0,
		PTF_PAT_P4    = 3'h1,
		PTF_PAT_P15   = 3'h2,
		PTF_PAT_P23   = 3'h3,
		PTF_PAT_QRSS  = 3'h4,
		PTF_PAT_FIXED = 3'h5
	} ptf_pat_t;
	typedef enum logic [2:0] {
		PTF_AL_WAIT  = 3'h1,
		PTF_AL_DELAY = 3'h2,
		PTF_AL_RUN   = 3'h4
	} ptf_align_t;
endpackage : ptf_pkg
`default_nettype wire

/* test/ptf_framer_model.sv */
// Framer model that drives transmit PCM bits aligned to the multiframe sync
`timescale 1ns/100ps
`default_nettype none
module ptf_framer_model #(
	parameter logic [7:0] SER_BYTE = 8'h5c,
	parameter logic [7:0] INS_BYTE = 8'h3a
) (
	// Sync in, data out
	input  wire logic clk_i,
	input  wire logic multiframe_sync_out_i,
	output logic      ser_o,
	output logic      ins_o
);
	logic [2:0] pos = 3'h0;
	initial ser_o = 1'b0;
	initial ins_o = 1'b0;
	// Bit 0 of frame 0 is presented in the cycle two clocks after the sync pulse
	always @(posedge clk_i)
	begin
		pos = multiframe_sync_out_i ? 3'h7 : pos + 3'h1;
		ser_o <= #1 SER_BYTE[3'h7 - pos];
		ins_o <= #1 INS_BYTE[3'h7 - pos];
	end
endmodule : ptf_framer_model
`default_nettype wire

/* test/testbench.sv */
// Testbench of the timeslot formatter
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic       clk, rst_n, ale, cs_n, rd_n, wr_n, ser, ins, multiframe_sync_out, mark, tx_ps, rx_ps;
	logic [7:0] ad_i, ad_o;
	logic       oe, stuff, rx_ser, rx_mf, drop;
	logic [2:0] tx_d, tx_v, tx_fs, rx_ref, take;
	int         bad_count, tests_run;
	ptf_formatter i_dut (.CLK_I(clk), .RST_N_I(rst_n), .CPU_AD_I(ad_i), .CPU_AD_O(ad_o), .CPU_AD_OE_O(oe),
		.CPU_ALE_I(ale), .CPU_CS_N_I(cs_n), .CPU_RD_N_I(rd_n), .CPU_WR_N_I(wr_n), .CPU_BUS_SEL_I(1'b0),
		.TX_SERIAL_IN_I(ser), .INSERT_DATA_IN_I(ins), .MULTIFRAME_SYNC_OUT_O(multiframe_sync_out), .INSERT_MARK_O(mark),
		.TX_CH_DATA_O(tx_d), .TX_CH_VALID_O(tx_v), .TX_PERIOD_SYNC_O(tx_ps), .TX_CH_FRAME_START_O(tx_fs),
		.TX_STUFF_ERR_I({2'h0, stuff}), .HDSL_RX_SYNC_REF_I(rx_ref), .RX_CH_DATA_I(3'h5), .RX_CH_TAKE_O(take),
		.RX_SERIAL_OUT_O(rx_ser), .RX_MULTIFRAME_SYNC_OUT_O(rx_mf), .DROP_MARK_O(drop), .RX_PERIOD_SYNC_O(rx_ps));
	ptf_framer_model i_framer (.clk_i(clk), .multiframe_sync_out_i(multiframe_sync_out), .ser_o(ser), .ins_o(ins));
	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			$display("BAD %s expected %h seen %h", name, exp, seen);
			bad_count++;
		end
	endtask : check
	task wr(input logic [7:0] a, input logic [7:0] d);
		ale = 1'b1;
		ad_i = a;
		step(1);
		ale = 1'b0;
		step(1);
		cs_n = 1'b0;
		wr_n = 1'b0;
		ad_i = d;
		step(2);
		wr_n = 1'b1;
		cs_n = 1'b1;
		step(1);
	endtask : wr
	task rd_check(input string name, input logic [7:0] a, input logic [7:0] exp);
		ale = 1'b1;
		ad_i = a;
		step(1);
		ale = 1'b0;
		step(1);
		cs_n = 1'b0;
		rd_n = 1'b0;
		step(2);
		check("read_enable", oe, 8'h01);
		check(name, ad_o, exp);
		rd_n = 1'b1;
		cs_n = 1'b1;
		step(1);
	endtask : rd_check
	task tbl(input logic [7:0] idx, input logic [7:0] val);
		wr(8'hdf, idx);
		wr(8'hed, val);
	endtask : tbl
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task t_regs;
		rd_check("mf_per", 8'hc7, 8'h01);
		rd_check("mf_len", 8'hc6, 8'h10);
		rd_check("unmapped", 8'h10, 8'h00);
		wr(8'hea, 8'h96);
		rd_check("fill", 8'hea, 8'h96);
		tbl(8'h01, 8'h08);
		rd_check("route_entry", 8'hed, 8'h08);
	endtask : t_regs
	task t_route;
		logic [2:0] ev[4];
		logic [7:0] eb[4];
		int s;
		int b;
		ev = '{3'h5, 3'h0, 3'h2, 3'h1};
		eb = '{8'h5c, 8'h00, 8'h3a, 8'h96};
		tbl(8'h00, 8'h05);
		tbl(8'h02, 8'h1a);
		tbl(8'h03, 8'h11);
		wr(8'he7, 8'h05);
		for (int i = 0; i < 5000 && multiframe_sync_out !== 1'b1; i++) step(1);
		step(2);
		for (int k = 0; k < 33; k++)
		begin
			check("insert_mark", mark, k / 8 == 1);
			if (k < 2) check("period_sync", tx_ps, k == 0);
			s = (k - 1) / 8;
			b = (k - 1) % 8;
			if (k > 0) check("tx_valid", tx_v, ev[s]);
			if (k > 0) check("tx_data", tx_d & tx_v, {3{eb[s][7 - b]}} & ev[s]);
			step(1);
		end
		wr(8'he6, 8'h02);
		step(1);
		for (int k = 0; k < 40; k++)
		begin
			check("async_valid", tx_v, 8'h05);
			check("async_mark", mark, 8'h00);
			step(1);
		end
	endtask : t_route
	task t_water;
		for (int n = 0; n < 2; n++)
		begin
			wr(8'h05, n ? 8'h01 : 8'h05);
			if (n == 0)
				wr(8'h0d, 8'h01);
			else
			begin
				stuff = 1'b1;
				step(1);
				stuff = 1'b0;
			end
			for (int i = 0; i < 5000 && tx_ps !== 1'b1; i++) step(1);
			for (int i = 0; i < 6; i++)
			begin
				check("frame_start", tx_fs[0], i == (n ? 1 : 5));
				step(1);
			end
		end
	endtask : t_water
	task t_rx;
		wr(8'he9, 8'h01);
		wr(8'hcd, 8'h02);
		wr(8'hc3, 8'h04);
		wr(8'hdf, 8'h00);
		wr(8'hee, 8'h82);
		wr(8'hdf, 8'h01);
		wr(8'hee, 8'h01);
		for (int c = 0; c < 3; c++)
		begin
			if (c == 2)
				wr(8'he6, 8'h01);
			rx_ref = c ? 3'h2 : 3'h1;
			step(1);
			rx_ref = 3'h0;
			for (int i = 1; i < 6; i++)
			begin
				check("rx_period_sync", rx_ps, c > 0 && i == 2);
				step(1);
			end
			for (int p = 3 - c; p < 16 && c > 0; p++)
			begin
				check("rx_serial", rx_ser, p >= 8);
				check("drop_mark", drop, p < 8);
				check("rx_mf_sync", rx_mf, p == 4);
				check("rx_take", take, (p + c < 8) ? 8'h02 : ((p + c < 16) ? 8'h01 : 8'h00));
				step(1);
			end
		end
	endtask : t_rx
	task tally_and_finish;
		$display("Checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	// ****************************************************************
	// Clock, sequence and watchdog
	// ****************************************************************
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial
	begin
		{rst_n, ale, ad_i, rx_ref, stuff} = '0;
		{cs_n, rd_n, wr_n} = 3'h7;
		repeat (3) @(posedge clk);
		#1 rst_n = 1'b1;
		t_regs;
		t_route;
		t_water;
		t_rx;
		tally_and_finish;
	end
	initial
	begin
		repeat (60000) @(posedge clk);
		bad_count++;
		tally_and_finish;
	end
endmodule : testbench
`default_nettype wire
